// ---- logic/tsa_pkg.sv ----
// constants and carrier types of the temperature sensor register block
// assumes a 200 MHz system clock and a single synchronous reset
package tsa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register selection codes
  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CFG = 3'h1;
  localparam logic [2:0] PTR_HYST = 3'h2;
  localparam logic [2:0] PTR_OTLIM = 3'h3;
  localparam logic [2:0] PTR_ONESHOT = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] HYST_RESET = 16'h4b00;
  localparam logic [15:0] OTLIM_RESET = 16'h5000;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] ONESHOT_RESET = 8'h00;
  localparam logic [15:0] TEMP_MASK = 16'hfff0;

  ////////////////////////////////////////////////////////////////////////////
  // configuration field positions
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_INTMODE = 1;
  localparam int CFG_POLARITY = 2;
  localparam int CFG_QUEUE_LO = 3;
  localparam int CFG_QUEUE_HI = 4;
  localparam int CFG_ONESHOT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // fault queue depths
  localparam logic [2:0] QUEUE_DEPTH_0 = 3'h1;
  localparam logic [2:0] QUEUE_DEPTH_1 = 3'h2;
  localparam logic [2:0] QUEUE_DEPTH_2 = 3'h4;
  localparam logic [2:0] QUEUE_DEPTH_3 = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // bus address and timing
  localparam logic [3:0] ADDR_FIXED = 4'h9;
  localparam int CONV_PERIOD_MS = 60;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int CONV_CYCLES = CONV_PERIOD_MS * CLK_FREQ_KHZ;

  // byte-level events from the serial slave
  typedef struct packed {
    logic txStart;
    logic wrValid;
    logic rdTaken;
    logic [7:0] data;
  } tsa_bus_evt_t;

endpackage

// ---- logic/tsa_i2c_slave.sv ----
// two-wire serial slave: start/stop, address match, byte shifting
// assumes scl and sda arrive asynchronously from the bus pins
`timescale 1ns/1ps
module tsa_i2c_slave
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic [6:0] devAddr,
  input wire logic [7:0] rdData,
  output tsa_pkg::tsa_bus_evt_t evt,
  output logic sdaOe
);

  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_ACK, SL_WR, SL_RD, SL_MACK}
    tsa_sl_state_t;

  logic [2:0] sclSync_r;
  logic [2:0] sdaSync_r;
  logic sclF_r;
  logic sdaF_r;
  logic sclPrev_r;
  logic sdaPrev_r;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  tsa_sl_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bitCnt_r;
  logic isRead_r;
  logic mAck_r;

  //////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers, change taken when stages two and three agree
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
      sclF_r <= 1'b1;
      sdaF_r <= 1'b1;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end
    else
    begin
      sclSync_r <= {sclSync_r[1:0], sclIn};
      sdaSync_r <= {sdaSync_r[1:0], sdaIn};
      if (sclSync_r[1] == sclSync_r[2])
        sclF_r <= sclSync_r[2];
      if (sdaSync_r[1] == sdaSync_r[2])
        sdaF_r <= sdaSync_r[2];
      sclPrev_r <= sclF_r;
      sdaPrev_r <= sdaF_r;
    end
  end

  assign sclRise = sclF_r & ~sclPrev_r;
  assign sclFall = ~sclF_r & sclPrev_r;
  assign startCond = sclF_r & sclPrev_r & sdaPrev_r & ~sdaF_r;
  assign stopCond = sclF_r & sclPrev_r & ~sdaPrev_r & sdaF_r;

  //////////////////////////////////////////////////////////////////////////////
  // byte engine
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= SL_IDLE;
      shift_r <= 8'h00;
      bitCnt_r <= 4'h0;
      isRead_r <= 1'b0;
      mAck_r <= 1'b0;
      evt <= '0;
      sdaOe <= 1'b0;
    end
    else
    begin
      evt.txStart <= 1'b0;
      evt.wrValid <= 1'b0;
      evt.rdTaken <= 1'b0;
      if (startCond)
      begin
        state_r <= SL_ADDR;
        bitCnt_r <= 4'h0;
        sdaOe <= 1'b0;
      end
      else if (stopCond)
      begin
        state_r <= SL_IDLE;
        sdaOe <= 1'b0;
      end
      else
      begin
        unique case (state_r)
          SL_IDLE:
            sdaOe <= 1'b0;
          SL_ADDR, SL_WR:
          begin
            if (sclRise && bitCnt_r != 4'h8)
            begin
              shift_r <= {shift_r[6:0], sdaF_r};
              bitCnt_r <= bitCnt_r + 4'h1;
            end
            else if (sclFall && bitCnt_r == 4'h8)
            begin
              if (state_r == SL_WR)
              begin
                evt.wrValid <= 1'b1;
                evt.data <= shift_r;
                sdaOe <= 1'b1;
                state_r <= SL_ACK;
              end
              else if (shift_r[7:1] == devAddr)
              begin
                evt.txStart <= 1'b1;
                isRead_r <= shift_r[0];
                sdaOe <= 1'b1;
                state_r <= SL_ACK;
              end
              else
                state_r <= SL_IDLE;
            end
          end
          SL_ACK:
          begin
            if (sclFall)
            begin
              bitCnt_r <= 4'h0;
              if (isRead_r)
              begin
                shift_r <= rdData;
                evt.rdTaken <= 1'b1;
                sdaOe <= ~rdData[7];
                state_r <= SL_RD;
              end
              else
              begin
                sdaOe <= 1'b0;
                state_r <= SL_WR;
              end
            end
          end
          SL_RD:
          begin
            if (sclFall)
            begin
              if (bitCnt_r == 4'h7)
              begin
                sdaOe <= 1'b0;
                state_r <= SL_MACK;
              end
              else
              begin
                shift_r <= {shift_r[6:0], 1'b0};
                sdaOe <= ~shift_r[6];
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          SL_MACK:
          begin
            if (sclRise)
              mAck_r <= ~sdaF_r;
            else if (sclFall)
            begin
              bitCnt_r <= 4'h0;
              if (mAck_r)
              begin
                shift_r <= rdData;
                evt.rdTaken <= 1'b1;
                sdaOe <= ~rdData[7];
                state_r <= SL_RD;
              end
              else
                state_r <= SL_IDLE;
            end
          end
        endcase
      end
    end
  end

endmodule

// ---- logic/tsa_sensor_regs.sv ----
// register set, conversion sequencing and alert control of the sensor
// assumes a converter on the same clock answering convStart with convDone
//
// What this block does
// - count a fault when a conversion exceeds the programmed over-temp limit
// - alert asserts only after the set number of back-to-back faults
// - config bits 4:3 pick fault count one, two, four or six
// - the low three pointer bits choose the register for data transfers
// - codes 0..4 select temp, config, hysteresis, over-temp, one-shot
// - the pointer is zero after reset, selecting the temperature
// - reset values: temp 0, config 0, hysteresis 75 C, over-temp 80 C
// - config, pointer, one-shot are one byte; temp and limits two
// - temperature is read-only; all else but the pointer is read/write
// - temperature is held as 16-bit two's complement, sign on top
// - two-byte reads send the upper byte first, then the lower
// - with config bit 5 clear a conversion starts every 60 ms
// - with bit 5 set, one conversion per one-shot write, then idle
// - config bit 2 sets alert polarity: 0 active low, 1 active high
// - config bit 1 selects comparator (0) or interrupt (1) alert mode
// - config bit 0 powers down all but the bus until cleared
// - bus address is 1001 then the three select pins, always sampled
`timescale 1ns/1ps
module tsa_sensor_regs
#(
  parameter int CONV_CYCLES = tsa_pkg::CONV_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelectPin2,
  input wire logic addrSelectPin1,
  input wire logic addrSelectPin0,
  output logic overTempAlertPinOut,
  output logic overTempAlertPinOe,
  output logic convStart,
  output logic analogPowerDown,
  input wire logic convDone,
  input wire logic [15:0] convData
);

  typedef enum logic {CV_IDLE, CV_BUSY} tsa_cv_state_t;

  tsa_pkg::tsa_bus_evt_t evt;
  logic [2:0] addrSync1_r;
  logic [2:0] addrSync2_r;
  logic [2:0] addrSync3_r;
  logic [2:0] addrStable_r;
  logic [7:0] ptr_r;
  logic [1:0] wrCnt_r;
  logic rdIdx_r;
  logic [15:0] temp_r;
  logic [7:0] cfg_r;
  logic [15:0] hyst_r;
  logic [15:0] otLim_r;
  logic [7:0] oneShot_r;
  logic [7:0] stage_r;
  logic oneShotReq_r;
  logic [31:0] timer_r;
  tsa_cv_state_t cvState_r;
  logic [2:0] faultCnt_r;
  logic alert_r;
  logic [7:0] rdData;
  logic startNow;
  logic doneEvt;
  logic [15:0] sample;
  logic faultNow;
  logic belowHyst;
  logic needMet;
  logic oneShotWr;

  function automatic logic [2:0] queueNeed(input logic [1:0] code);
    unique case (code)
      2'h0: queueNeed = tsa_pkg::QUEUE_DEPTH_0;
      2'h1: queueNeed = tsa_pkg::QUEUE_DEPTH_1;
      2'h2: queueNeed = tsa_pkg::QUEUE_DEPTH_2;
      2'h3: queueNeed = tsa_pkg::QUEUE_DEPTH_3;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // serial slave and address pins
  tsa_i2c_slave u_slave
  (
    .clk(clk),
    .reset(reset),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .devAddr({tsa_pkg::ADDR_FIXED, addrStable_r}),
    .rdData(rdData),
    .evt(evt),
    .sdaOe(sdaOe)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      addrSync1_r <= 3'h0;
      addrSync2_r <= 3'h0;
      addrSync3_r <= 3'h0;
      addrStable_r <= 3'h0;
      sdaOut <= 1'b0;
    end
    else
    begin
      addrSync1_r <= {addrSelectPin2, addrSelectPin1, addrSelectPin0};
      addrSync2_r <= addrSync1_r;
      addrSync3_r <= addrSync2_r;
      if (addrSync2_r == addrSync3_r)
        addrStable_r <= addrSync3_r;
      sdaOut <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes
  assign oneShotWr = evt.wrValid && wrCnt_r == 2'h1
    && ptr_r[2:0] == tsa_pkg::PTR_ONESHOT;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ptr_r <= tsa_pkg::PTR_RESET;
      wrCnt_r <= 2'h0;
      cfg_r <= tsa_pkg::CFG_RESET;
      hyst_r <= tsa_pkg::HYST_RESET;
      otLim_r <= tsa_pkg::OTLIM_RESET;
      oneShot_r <= tsa_pkg::ONESHOT_RESET;
      stage_r <= 8'h00;
    end
    else if (evt.txStart)
      wrCnt_r <= 2'h0;
    else if (evt.wrValid)
    begin
      if (wrCnt_r != 2'h3)
        wrCnt_r <= wrCnt_r + 2'h1;
      if (wrCnt_r == 2'h0)
        ptr_r <= evt.data;
      else if (wrCnt_r == 2'h1)
      begin
        unique case (ptr_r[2:0])
          tsa_pkg::PTR_CFG: cfg_r <= evt.data;
          tsa_pkg::PTR_ONESHOT: oneShot_r <= evt.data;
          tsa_pkg::PTR_HYST, tsa_pkg::PTR_OTLIM: stage_r <= evt.data;
          default: ;
        endcase
      end
      else if (wrCnt_r == 2'h2)
      begin
        if (ptr_r[2:0] == tsa_pkg::PTR_HYST)
          hyst_r <= {stage_r, evt.data};
        else if (ptr_r[2:0] == tsa_pkg::PTR_OTLIM)
          otLim_r <= {stage_r, evt.data};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads, upper byte first for wide registers
  always_comb
  begin
    unique case (ptr_r[2:0])
      tsa_pkg::PTR_TEMP: rdData = rdIdx_r ? temp_r[7:0] : temp_r[15:8];
      tsa_pkg::PTR_CFG: rdData = cfg_r;
      tsa_pkg::PTR_HYST: rdData = rdIdx_r ? hyst_r[7:0] : hyst_r[15:8];
      tsa_pkg::PTR_OTLIM: rdData = rdIdx_r ? otLim_r[7:0] : otLim_r[15:8];
      tsa_pkg::PTR_ONESHOT: rdData = oneShot_r;
      default: rdData = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdIdx_r <= 1'b0;
    else if (evt.txStart)
      rdIdx_r <= 1'b0;
    else if (evt.rdTaken)
      rdIdx_r <= ~rdIdx_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion sequencing
  assign startNow = cvState_r == CV_IDLE && !cfg_r[tsa_pkg::CFG_SHUTDOWN]
    && (cfg_r[tsa_pkg::CFG_ONESHOT] ? oneShotReq_r : timer_r == 32'h0);
  assign doneEvt = cvState_r == CV_BUSY && convDone;

  always_ff @(posedge clk)
  begin
    if (reset)
      timer_r <= 32'h0;
    else if (cfg_r[tsa_pkg::CFG_SHUTDOWN] || cfg_r[tsa_pkg::CFG_ONESHOT])
      timer_r <= 32'h0;
    else if (startNow)
      timer_r <= 32'(CONV_CYCLES - 1);
    else if (timer_r != 32'h0)
      timer_r <= timer_r - 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      oneShotReq_r <= 1'b0;
    else if (oneShotWr)
      oneShotReq_r <= 1'b1;
    else if (startNow)
      oneShotReq_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cvState_r <= CV_IDLE;
      convStart <= 1'b0;
      analogPowerDown <= 1'b0;
    end
    else
    begin
      convStart <= startNow;
      analogPowerDown <= cfg_r[tsa_pkg::CFG_SHUTDOWN]
        || (cfg_r[tsa_pkg::CFG_ONESHOT] && cvState_r == CV_IDLE
        && !startNow);
      unique case (cvState_r)
        CV_IDLE: if (startNow) cvState_r <= CV_BUSY;
        CV_BUSY: if (convDone) cvState_r <= CV_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // result, fault queue and alert
  assign sample = convData & tsa_pkg::TEMP_MASK;
  assign faultNow = $signed(sample) > $signed(otLim_r);
  assign belowHyst = $signed(sample) < $signed(hyst_r);
  assign needMet = faultNow
    && 3'(faultCnt_r + 3'h1) >= queueNeed(cfg_r[4:3]);

  always_ff @(posedge clk)
  begin
    if (reset)
      temp_r <= tsa_pkg::TEMP_RESET;
    else if (doneEvt)
      temp_r <= sample;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      faultCnt_r <= 3'h0;
    else if (doneEvt)
    begin
      if (!faultNow)
        faultCnt_r <= 3'h0;
      else if (cfg_r[tsa_pkg::CFG_INTMODE] && needMet)
        faultCnt_r <= 3'h0;
      else if (faultCnt_r != tsa_pkg::QUEUE_DEPTH_3)
        faultCnt_r <= faultCnt_r + 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      alert_r <= 1'b0;
    else if (doneEvt && needMet)
      alert_r <= 1'b1;
    else if (!cfg_r[tsa_pkg::CFG_INTMODE] && doneEvt && belowHyst)
      alert_r <= 1'b0;
    else if (cfg_r[tsa_pkg::CFG_INTMODE] && evt.rdTaken)
      alert_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      overTempAlertPinOut <= 1'b0;
      overTempAlertPinOe <= 1'b0;
    end
    else
    begin
      overTempAlertPinOut <= 1'b0;
      overTempAlertPinOe <= alert_r ^ cfg_r[tsa_pkg::CFG_POLARITY];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_ptr_load: assert property (evt.wrValid && wrCnt_r == 2'h0 && !evt.txStart
    |=> ptr_r == $past(evt.data)) else $error("pointer not loaded");
  a_reset_ptr: assert property ($fell(reset) |-> ptr_r == 8'h00
    && hyst_r == 16'h4b00) else $error("bad reset values");
  a_reset_limits: assert property ($fell(reset) |-> otLim_r == 16'h5000
    && cfg_r == 8'h00 && temp_r == 16'h0000) else $error("bad reset");
  a_temp_readonly: assert property (evt.wrValid && ptr_r[2:0] == 3'h0
    && !doneEvt |=> $stable(temp_r)) else $error("temperature written");
  a_queue_fire: assert property (doneEvt && needMet |=> alert_r
    ##1 overTempAlertPinOe == !cfg_r[2]) else $error("alert not raised");
  a_no_early: assert property (doneEvt && faultNow && !alert_r
    && 3'(faultCnt_r + 3'h1) < queueNeed(cfg_r[4:3]) |=> !alert_r)
    else $error("alert raised too early");
  a_pin_polarity: assert property (##1 overTempAlertPinOe ==
    $past(alert_r ^ cfg_r[2])) else $error("alert pin level wrong");
  a_shutdown_idle: assert property (cfg_r[0] && $past(cfg_r[0])
    |-> !convStart && analogPowerDown) else $error("converted in shutdown");
  a_oneshot_once: assert property (cfg_r[5] && $past(cfg_r[5])
    && convStart |-> $past(oneShotReq_r) ##1 !oneShotReq_r || oneShotWr)
    else $error("one-shot start without trigger");
  a_int_clear: assert property (cfg_r[1] && evt.rdTaken
    && !(doneEvt && needMet) |=> !alert_r ##1 overTempAlertPinOe == cfg_r[2])
    else $error("interrupt not cleared by read");
  a_read_order: assert property (evt.rdTaken && !rdIdx_r
    && ptr_r[2:0] == 3'h3 |-> u_slave.shift_r == otLim_r[15:8])
    else $error("upper byte not first");
  a_period: assert property (convStart && !cfg_r[5] && !cfg_r[0]
    |-> timer_r == 32'(CONV_CYCLES - 1)) else $error("period not reloaded");

  c_fault_alert: cover property (doneEvt && needMet ##1 alert_r);
  c_int_clear: cover property (cfg_r[1] && alert_r ##1 evt.rdTaken);
  c_oneshot: cover property (cfg_r[5] && oneShotWr ##[1:4] convStart);
  c_limit_write: cover property (evt.wrValid && wrCnt_r == 2'h2);

endmodule

// ---- sim/tsa_bus_master.sv ----
// partner model: two-wire bus master, data line with a pull-up
// assumes the device samples both bus lines on the system clock
`timescale 1ns/1ps
module tsa_bus_master
(
  input wire logic clk,
  input wire logic devSdaOe,
  output logic scl,
  output logic sda
);
  logic mstLow;

  // released line goes high through the pull-up
  assign sda = ~(mstLow | devSdaOe);

  initial
  begin
    scl = 1'b1;
    mstLow = 1'b0;
  end

  task automatic q();
    repeat (8) @(negedge clk);
  endtask

  // data changes only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    mstLow = ~b;
    q();
    scl = 1'b1;
    q();
    s = sda;
    q();
    scl = 1'b0;
    q();
  endtask

  task automatic start();
    mstLow = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask

  task automatic stop();
    mstLow = 1'b1;
    q();
    scl = 1'b1;
    q();
    mstLow = 1'b0;
    q();
  endtask

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(nack, s);
  endtask

  // address, pointer, then data: two bytes upper first for limits
  task automatic write(input logic [6:0] a, input logic [7:0] p,
                       input int n, input logic [15:0] d, output logic ok);
    logic k;
    start();
    wbyte({a, 1'b0}, ok);
    if (ok)
    begin
      wbyte(p, k);
      ok = ok & k;
      if (n == 2)
        wbyte(d[15:8], k);
      if (n >= 1)
        wbyte(d[7:0], k);
    end
    stop();
  endtask

  // upper byte taken first, last byte refused to end the read
  task automatic read(input logic [6:0] a, input int n,
                      output logic [15:0] d, output logic ok);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = 8'h00;
    lo = 8'h00;
    start();
    wbyte({a, 1'b1}, ok);
    if (ok && n == 2)
      rbyte(1'b0, hi);
    if (ok)
      rbyte(1'b1, lo);
    stop();
    d = {hi, lo};
  endtask
endmodule

// ---- sim/tb.sv ----
// testbench of the sensor register block with a behavioural converter
// assumes the bus master model and the package are compiled before
`timescale 1ns/1ps
module tb;
  localparam int CONV = 1200;
  logic clk, reset, scl, sda, sdaOut, sdaOe, alertOut, alertOe;
  logic convStart, analogPowerDown, convDone, ok;
  logic [15:0] tempIn, rv;
  logic [2:0] pins;
  logic [6:0] dev;
  int error_cnt, n_compared, doneCnt, startCnt, convWait, cnt, s;
  int qn[4] = '{1, 2, 4, 6};

  assign dev = {tsa_pkg::ADDR_FIXED, pins};

  tsa_sensor_regs #(.CONV_CYCLES(CONV)) u_dut (.clk(clk), .reset(reset),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelectPin2(pins[2]), .addrSelectPin1(pins[1]),
    .addrSelectPin0(pins[0]), .overTempAlertPinOut(alertOut),
    .overTempAlertPinOe(alertOe), .convStart(convStart),
    .analogPowerDown(analogPowerDown), .convDone(convDone),
    .convData(tempIn));

  tsa_bus_master u_mst (.clk(clk), .devSdaOe(sdaOe), .scl(scl), .sda(sda));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////
  // converter: answers three cycles after each start
  always @(negedge clk)
  begin
    convDone <= 1'b0;
    if (convWait > 0)
    begin
      convWait <= convWait - 1;
      if (convWait == 1)
        convDone <= 1'b1;
    end
    else if (convStart === 1'b1)
      convWait <= 3;
  end

  always @(posedge clk)
  begin
    if (convDone)
      doneCnt++;
    if (convStart === 1'b1)
      startCnt++;
  end

  ////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic done_test(input string name);
    $display("test %0s finished, mismatches %0d", name, error_cnt);
  endtask

  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
    u_mst.write(dev, p, n, d, ok);
    chk({15'h0, ok}, 16'h1);
  endtask

  task automatic rd(input logic [7:0] p, input int n, output logic [15:0] d);
    wr(p, 0, 16'h0);
    u_mst.read(dev, n, d, ok);
    chk({15'h0, ok}, 16'h1);
  endtask

  task automatic wait_conv(input int n);
    int t;
    t = doneCnt + n;
    for (int i = 0; i < 4 * CONV * n && doneCnt < t; i++)
      @(negedge clk);
    if (doneCnt < t)
    begin
      error_cnt++;
      complete_run();
    end
    repeat (3) @(negedge clk);
  endtask

  ////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    pins = 3'h5;
    tempIn = 16'h123f;
    convDone = 1'b0;
    convWait = 0;
    error_cnt = 0;
    n_compared = 0;
    doneCnt = 0;
    startCnt = 0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (10) @(negedge clk);
    chk({15'h0, alertOe}, 16'h0);
    u_mst.read(dev, 2, rv, ok);
    chk(rv, 16'h1230);
    rd(1, 1, rv);
    chk(rv, 16'h0000);
    rd(2, 2, rv);
    chk(rv, 16'h4b00);
    rd(3, 2, rv);
    chk(rv, 16'h5000);
    done_test("reset");
    u_mst.write({4'h9, 3'h2}, 0, 0, 16'h0, ok);
    chk({15'h0, ok}, 16'h0);
    pins = 3'h2;
    repeat (10) @(negedge clk);
    wr(2, 2, 16'h3c00);
    wr(8'hf3, 2, 16'h4600);
    wr(4, 1, 16'h00a5);
    wr(0, 2, 16'hffff);
    wr(5, 1, 16'h0077);
    rd(2, 2, rv);
    chk(rv, 16'h3c00);
    rd(3, 2, rv);
    chk(rv, 16'h4600);
    rd(4, 1, rv);
    chk(rv, 16'h00a5);
    rd(0, 2, rv);
    chk(rv, 16'h1230);
    rd(5, 1, rv);
    chk(rv, 16'h0000);
    done_test("registers");
    for (int q = 0; q < 4; q++)
    begin
      tempIn = 16'h3000;
      wr(1, 1, 16'(q << 3));
      wait_conv(2);
      chk({15'h0, alertOe}, 16'h0);
      tempIn = 16'h4700;
      for (cnt = 1; cnt < 8; cnt++)
      begin
        wait_conv(1);
        if (alertOe === 1'b1)
          break;
      end
      chk(16'(cnt), 16'(qn[q]));
      tempIn = 16'h4000;
      wait_conv(1);
      chk({15'h0, alertOe}, 16'h1);
      tempIn = 16'h3000;
      wait_conv(1);
      chk({15'h0, alertOe}, 16'h0);
    end
    done_test("fault queue");
    wr(1, 1, 16'h0004);
    wait_conv(1);
    chk({15'h0, alertOe}, 16'h1);
    tempIn = 16'h4700;
    wait_conv(1);
    chk({alertOut, sdaOut, 13'h0, alertOe}, 16'h0);
    tempIn = 16'h3000;
    wr(1, 1, 16'h0002);
    rd(1, 1, rv);
    chk({15'h0, alertOe}, 16'h0);
    wait_conv(1);
    chk({15'h0, alertOe}, 16'h0);
    tempIn = 16'h4700;
    wait_conv(1);
    tempIn = 16'h3000;
    wait_conv(1);
    chk({15'h0, alertOe}, 16'h1);
    rd(1, 1, rv);
    chk(rv, 16'h0002);
    chk({15'h0, alertOe}, 16'h0);
    done_test("alert modes");
    wr(1, 1, 16'h0001);
    s = startCnt;
    repeat (3 * CONV) @(negedge clk);
    chk({15'h0, analogPowerDown}, 16'h1);
    chk(16'(startCnt - s), 16'h0);
    wr(1, 1, 16'h0000);
    wait_conv(1);
    chk({15'h0, analogPowerDown}, 16'h0);
    wr(1, 1, 16'h0020);
    s = startCnt;
    repeat (3 * CONV) @(negedge clk);
    chk({15'h0, analogPowerDown}, 16'h1);
    chk(16'(startCnt - s), 16'h0);
    tempIn = 16'h0d95;
    wr(4, 1, 16'h0001);
    repeat (3 * CONV) @(negedge clk);
    chk(16'(startCnt - s), 16'h1);
    rd(0, 2, rv);
    chk(rv, 16'h0d90);
    done_test("power modes");
    wr(1, 1, 16'h0000);
    wait_conv(1);
    s = startCnt;
    for (cnt = 0; cnt < 3 * CONV && startCnt == s; cnt++)
      @(negedge clk);
    s = startCnt;
    for (cnt = 0; cnt < 3 * CONV && startCnt == s; cnt++)
      @(negedge clk);
    chk({15'h0, cnt >= CONV && cnt <= CONV + 2}, 16'h1);
    done_test("period");
    complete_run();
  end
endmodule
